//--- pkg/ccd_pkg.sv
// Types shared by the child count decrement block
package ccd_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_CHECK = 5'h02,
    ST_DECR  = 5'h04,
    ST_FIX   = 5'h08,
    ST_DONE  = 5'h10
  } ccd_state_type;
  typedef enum logic [2:0] {
    PT_CTRL_STRUCT = 3'h0,
    PT_THREAD      = 3'h1,
    PT_REGULAR     = 3'h2,
    PT_TRIMMED     = 3'h4,
    FIRST_SHADOW_STACK_PAGE_TYPE    = 3'h5,
    PT_SS_LATER    = 3'h6
  } ccd_page_type;
endpackage

//--- pkg/ccd_regs.svh
// Register offsets, field positions and constants of the child count decrement block
// Functional notes
// - Leaf index zero in the leaf register starts the child count decrement.
// - Only privilege level zero may run the leaf; others get protection fault.
// - Operand linear addresses use the data segment only; overrides are ignored.
// - Page operand not 4K aligned gives protection fault zero before other checks; code tests leaf, privilege, segment and canonical first.
// - Operand outside the protected page cache gives enclave page fault on it.
// - Target page busy: set zero flag, conflict code in RAX, go to flag clearing.
// - Target map entry invalid gives enclave page fault on the target address.
// - Regular, thread, trimmed or shadow-stack page takes its parent from the map.
// - Control structure page is its own parent; other types give page fault.
// - Parent differing from the second operand's address gives protection fault zero.
// - Decrement atomically; underflow restores by increment, sets zero flag, error code.
// - Successful decrement clears zero flag and returns zero in RAX.
// - Zero flag set only on conflict or underflow, cleared otherwise on completion.
// - 32-bit mode: operand beyond segment limit or unusable segment gives protection fault.
// - 64-bit mode: non-canonical operand address gives protection fault.
// - Target page is read-write from outside, control structure readable inside.
// - Target held shared with conflict reporting; control structure accessed concurrently.
// - Runs alongside accept, modify, add, extend, initialise, tracking leaves without conflict.
// - Child count is a 64-bit integer, parent address a 64-bit physical address.
// - Ordinary page fault on operand access raises page fault with error code.
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH
// -------------------------------------------------------------
// Register byte offsets
// -------------------------------------------------------------
`define CCD_OFF_CTRL 8'h00
`define CCD_OFF_LEAF 8'h04
`define CCD_OFF_RBX_LO 8'h08
`define CCD_OFF_RBX_HI 8'h0c
`define CCD_OFF_RCX_LO 8'h10
`define CCD_OFF_RCX_HI 8'h14
`define CCD_OFF_DS_BASE 8'h18
`define CCD_OFF_DS_LIMIT 8'h1c
`define CCD_OFF_STATUS 8'h20
`define CCD_OFF_RAX_LO 8'h24
`define CCD_OFF_RAX_HI 8'h28
`define CCD_OFF_FADDR_LO 8'h2c
`define CCD_OFF_FADDR_HI 8'h30
`define CCD_OFF_MAP_SEL 8'h34
`define CCD_OFF_MAP_ATTR 8'h38
`define CCD_OFF_MAP_OWNER 8'h3c
`define CCD_OFF_CNT_LO 8'h40
`define CCD_OFF_CNT_HI 8'h44
`define CCD_OFF_FLAGS 8'h48
// -------------------------------------------------------------
// Field positions
// -------------------------------------------------------------
`define CCD_CTRL_GO 0
`define CCD_CTRL_CPL_LO 1
`define CCD_CTRL_CPL_HI 2
`define CCD_CTRL_MODE64 3
`define CCD_CTRL_DS_UNUSABLE 4
`define CCD_CTRL_SEG_OVR 5
`define CCD_CTRL_XLAT_FAULT 6
`define CCD_ST_BUSY 0
`define CCD_ST_DONE 1
`define CCD_ST_GP 2
`define CCD_ST_PF 3
`define CCD_ST_PFEC_ENC 4
`define CCD_FL_CF 0
`define CCD_FL_PF 2
`define CCD_FL_AF 4
`define CCD_FL_ZF 6
`define CCD_FL_SF 7
`define CCD_FL_OF 11
`define CCD_ATTR_VALID 0
`define CCD_ATTR_BUSY 1
`define CCD_ATTR_TYPE_LO 4
`define CCD_ATTR_TYPE_HI 6
// -------------------------------------------------------------
// Constants
// -------------------------------------------------------------
`define CCD_LEAF_DEC 32'h0000_0000
`define CCD_CPL_KERNEL 2'h0
`define CCD_PAGE_SHIFT 12
`define CCD_VA_MSB 47
`define CCD_RAX_OK 64'h0000_0000_0000_0000
`define CCD_ERR_CONFLICT 64'h0000_0000_0000_0007
`define CCD_ERR_INV_CNT 64'h0000_0000_0000_0008
`define CCD_FLAGS_RST 32'h0000_0002
`define CCD_RESP_OKAY 2'h0
`define CCD_RESP_SLVERR 2'h2
`endif

//--- src/ccd_top.sv
// Child count decrement leaf engine with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ccd_regs.svh"
module ccd_top #(
  parameter int PAGES = 16,
  parameter logic [63:0] CACHE_BASE = 64'h0000_0000_8000_0000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int IW = $clog2(PAGES);
  // Page index slicing and the select register only serve power-of-two sizes
  if (PAGES < 2 || PAGES > 256 || (PAGES & (PAGES - 1)) != 0) begin : g_bad_pages
    $error("PAGES must be a power of two between 2 and 256");
  end

  // -------------------------------------------------------------
  // Storage and state
  // -------------------------------------------------------------
  logic [31:0] ctrl_ff, leaf_ff, ds_base_ff, ds_limit_ff, flags_ff;
  logic [63:0] rbx_ff, rcx_ff, rax_ff, faddr_ff;
  logic [7:0] status_ff, map_sel_ff;
  logic map_valid_ff [PAGES];
  logic map_busy_ff [PAGES];
  ccd_pkg::ccd_page_type map_type_ff [PAGES];
  logic [IW-1:0] map_owner_ff [PAGES];
  logic [63:0] cnt_ff [PAGES];
  ccd_pkg::ccd_state_type state_ff;
  logic [IW-1:0] par_idx_ff;
  logic go_pulse;

  // -------------------------------------------------------------
  // AXI4-Lite write channel: address and data taken in any order
  // -------------------------------------------------------------
  logic aw_held_ff, w_held_ff;
  logic [7:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic wr_do;
  assign wr_do = aw_held_ff && w_held_ff && !s_axi_bvalid;

  // Address and data latches, one word each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_do) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_do) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Ready is low while a word is held, so one write is in flight at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCD_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_known(aw_addr_ff) ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Decoding shared by the read and write paths
  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a[1:0] == 2'h0) && (a <= `CCD_OFF_FLAGS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // Software-owned operand registers; frozen while the leaf runs so inputs stay stable
  logic sw_ok;
  assign sw_ok = wr_do && state_ff == ccd_pkg::ST_IDLE;
  assign go_pulse = sw_ok && aw_addr_ff == `CCD_OFF_CTRL && w_strb_ff[0] &&
                    w_data_ff[`CCD_CTRL_GO];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= 32'h0000_0000;
      leaf_ff <= 32'hffff_ffff;
      rbx_ff <= 64'h0;
      rcx_ff <= 64'h0;
      ds_base_ff <= 32'h0000_0000;
      ds_limit_ff <= 32'hffff_ffff;
      map_sel_ff <= 8'h00;
    end else if (sw_ok) begin
      unique case (aw_addr_ff)
        `CCD_OFF_CTRL: ctrl_ff <= merge(ctrl_ff, w_data_ff, w_strb_ff) & 32'h0000_007e;
        `CCD_OFF_LEAF: leaf_ff <= merge(leaf_ff, w_data_ff, w_strb_ff);
        `CCD_OFF_RBX_LO: rbx_ff[31:0] <= merge(rbx_ff[31:0], w_data_ff, w_strb_ff);
        `CCD_OFF_RBX_HI: rbx_ff[63:32] <= merge(rbx_ff[63:32], w_data_ff, w_strb_ff);
        `CCD_OFF_RCX_LO: rcx_ff[31:0] <= merge(rcx_ff[31:0], w_data_ff, w_strb_ff);
        `CCD_OFF_RCX_HI: rcx_ff[63:32] <= merge(rcx_ff[63:32], w_data_ff, w_strb_ff);
        `CCD_OFF_DS_BASE: ds_base_ff <= merge(ds_base_ff, w_data_ff, w_strb_ff);
        `CCD_OFF_DS_LIMIT: ds_limit_ff <= merge(ds_limit_ff, w_data_ff, w_strb_ff);
        `CCD_OFF_MAP_SEL: map_sel_ff <= 8'(merge({24'h0, map_sel_ff}, w_data_ff, w_strb_ff));
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------
  // Address formation and checks
  // -------------------------------------------------------------
  logic mode64;
  logic [63:0] lin_rbx, lin_rcx;
  logic [63:0] rel_rbx, rel_rcx;
  logic [IW-1:0] tgt_idx, sec_idx, own_idx;
  logic [63:0] parent_pa;
  logic lim_bad, canon_bad, tgt_out, sec_out, type_owned;
  assign mode64 = ctrl_ff[`CCD_CTRL_MODE64];
  // Data segment only; the override bit is never looked at
  assign lin_rbx = mode64 ? rbx_ff : {32'h0, ds_base_ff + rbx_ff[31:0]};
  assign lin_rcx = mode64 ? rcx_ff : {32'h0, ds_base_ff + rcx_ff[31:0]};
  assign lim_bad = !mode64 && (ctrl_ff[`CCD_CTRL_DS_UNUSABLE] ||
                   rbx_ff[31:0] > ds_limit_ff || rcx_ff[31:0] > ds_limit_ff);
  assign canon_bad = mode64 && (!(&lin_rbx[63:`CCD_VA_MSB] || ~|lin_rbx[63:`CCD_VA_MSB]) ||
                     !(&lin_rcx[63:`CCD_VA_MSB] || ~|lin_rcx[63:`CCD_VA_MSB]));
  assign rel_rbx = lin_rbx - CACHE_BASE;
  assign rel_rcx = lin_rcx - CACHE_BASE;
  // Identity translation: the cache window is a fixed physical range
  assign tgt_out = lin_rbx < CACHE_BASE || (rel_rbx >> `CCD_PAGE_SHIFT) >= 64'(PAGES);
  assign sec_out = lin_rcx < CACHE_BASE || (rel_rcx >> `CCD_PAGE_SHIFT) >= 64'(PAGES);
  assign tgt_idx = rel_rbx[`CCD_PAGE_SHIFT +: IW];
  assign sec_idx = rel_rcx[`CCD_PAGE_SHIFT +: IW];
  assign type_owned = map_type_ff[tgt_idx] inside {ccd_pkg::PT_REGULAR, ccd_pkg::PT_THREAD,
                      ccd_pkg::PT_TRIMMED, ccd_pkg::FIRST_SHADOW_STACK_PAGE_TYPE, ccd_pkg::PT_SS_LATER};
  // Parent comes from the owner field, or is the page itself
  assign own_idx = type_owned ? map_owner_ff[tgt_idx] : tgt_idx;
  assign parent_pa = CACHE_BASE + (64'(own_idx) << `CCD_PAGE_SHIFT);

  // -------------------------------------------------------------
  // Leaf sequencer
  // -------------------------------------------------------------
  logic [63:0] cnt_now;
  assign cnt_now = cnt_ff[par_idx_ff];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ccd_pkg::ST_IDLE;
      status_ff <= 8'h00;
      rax_ff <= `CCD_RAX_OK;
      faddr_ff <= 64'h0;
      flags_ff <= `CCD_FLAGS_RST;
      par_idx_ff <= '0;
    end else begin
      unique case (state_ff)
        ccd_pkg::ST_IDLE: begin
          if (go_pulse) begin
            state_ff <= ccd_pkg::ST_CHECK;
            status_ff <= 8'h01;
          end else if (sw_ok && aw_addr_ff == `CCD_OFF_FLAGS) begin
            flags_ff <= merge(flags_ff, w_data_ff, w_strb_ff);
          end
        end
        ccd_pkg::ST_CHECK: begin
          // Faults stop here and leave RAX, flags and counter alone
          state_ff <= ccd_pkg::ST_IDLE;
          status_ff <= 8'h02;
          faddr_ff <= lin_rbx;
          par_idx_ff <= own_idx;
          if (leaf_ff != `CCD_LEAF_DEC) begin
            status_ff <= 8'h06; // Unknown leaf is refused
          end else if (ctrl_ff[`CCD_CTRL_CPL_HI:`CCD_CTRL_CPL_LO] != `CCD_CPL_KERNEL) begin
            status_ff <= 8'h06;
          end else if (lim_bad || canon_bad) begin
            status_ff <= 8'h06;
          end else if (rbx_ff[`CCD_PAGE_SHIFT-1:0] != '0) begin
            status_ff <= 8'h06;
          end else if (ctrl_ff[`CCD_CTRL_XLAT_FAULT]) begin
            status_ff <= 8'h0a; // Plain page fault without enclave bit
          end else if (tgt_out) begin
            status_ff <= 8'h1a;
          end else if (sec_out) begin
            status_ff <= 8'h1a;
            faddr_ff <= lin_rcx;
          end else if (map_busy_ff[tgt_idx]) begin
            state_ff <= ccd_pkg::ST_DONE; // Shared hold lost
            status_ff <= 8'h01;
            rax_ff <= `CCD_ERR_CONFLICT;
            flags_ff[`CCD_FL_ZF] <= 1'b1;
          end else if (!map_valid_ff[tgt_idx]) begin
            status_ff <= 8'h1a;
          end else if (!type_owned && map_type_ff[tgt_idx] != ccd_pkg::PT_CTRL_STRUCT) begin
            status_ff <= 8'h1a;
          end else if (!map_valid_ff[sec_idx] ||
                       map_type_ff[sec_idx] != ccd_pkg::PT_CTRL_STRUCT) begin
            status_ff <= 8'h1a;
            faddr_ff <= lin_rcx;
          end else if (parent_pa != lin_rcx) begin
            status_ff <= 8'h06;
          end else begin
            state_ff <= ccd_pkg::ST_DECR;
            status_ff <= 8'h01;
          end
        end
        ccd_pkg::ST_DECR: begin
          // Underflow takes the restoring step
          state_ff <= (cnt_now == 64'h0) ? ccd_pkg::ST_FIX : ccd_pkg::ST_DONE;
          if (cnt_now != 64'h0) begin
            rax_ff <= `CCD_RAX_OK;
            flags_ff[`CCD_FL_ZF] <= 1'b0;
          end
        end
        ccd_pkg::ST_FIX: begin
          state_ff <= ccd_pkg::ST_DONE;
          rax_ff <= `CCD_ERR_INV_CNT;
          flags_ff[`CCD_FL_ZF] <= 1'b1;
        end
        ccd_pkg::ST_DONE: begin
          state_ff <= ccd_pkg::ST_IDLE;
          status_ff <= 8'h02;
          flags_ff[`CCD_FL_CF] <= 1'b0;
          flags_ff[`CCD_FL_PF] <= 1'b0;
          flags_ff[`CCD_FL_AF] <= 1'b0;
          flags_ff[`CCD_FL_OF] <= 1'b0;
          flags_ff[`CCD_FL_SF] <= 1'b0;
        end
      endcase
    end
  end

  // -------------------------------------------------------------
  // Page map and counters; one generate slice per page
  // -------------------------------------------------------------
  // The busy bit stands for another leaf holding the page exclusively; the
  // listed cooperating leaves never set it, so they run alongside
  for (genvar g = 0; g < PAGES; g++) begin : g_page
    logic sel_wr;
    assign sel_wr = wr_do && map_sel_ff == 8'(g);
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        map_valid_ff[g] <= 1'b0;
        map_busy_ff[g] <= 1'b0;
        map_type_ff[g] <= ccd_pkg::PT_REGULAR;
        map_owner_ff[g] <= '0;
      end else if (sel_wr && aw_addr_ff == `CCD_OFF_MAP_ATTR && w_strb_ff[0]) begin
        // Map entries may change mid-leaf; only the busy bit is sampled for conflict
        map_valid_ff[g] <= w_data_ff[`CCD_ATTR_VALID];
        map_busy_ff[g] <= w_data_ff[`CCD_ATTR_BUSY];
        map_type_ff[g] <= ccd_pkg::ccd_page_type'(w_data_ff[`CCD_ATTR_TYPE_HI:`CCD_ATTR_TYPE_LO]);
      end else if (sel_wr && aw_addr_ff == `CCD_OFF_MAP_OWNER) begin
        map_owner_ff[g] <= w_data_ff[IW-1:0];
      end
    end
    // Locked update: the engine owns the counter while it runs
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_ff[g] <= 64'h0;
      end else if (par_idx_ff == IW'(g) && state_ff == ccd_pkg::ST_DECR) begin
        cnt_ff[g] <= cnt_ff[g] - 64'h1;
      end else if (par_idx_ff == IW'(g) && state_ff == ccd_pkg::ST_FIX) begin
        cnt_ff[g] <= cnt_ff[g] + 64'h1;
      end else if (sel_wr && state_ff == ccd_pkg::ST_IDLE &&
                   aw_addr_ff == `CCD_OFF_CNT_LO) begin
        cnt_ff[g][31:0] <= merge(cnt_ff[g][31:0], w_data_ff, w_strb_ff);
      end else if (sel_wr && state_ff == ccd_pkg::ST_IDLE &&
                   aw_addr_ff == `CCD_OFF_CNT_HI) begin
        cnt_ff[g][63:32] <= merge(cnt_ff[g][63:32], w_data_ff, w_strb_ff);
      end
    end
  end

  // -------------------------------------------------------------
  // AXI4-Lite read channel
  // -------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [IW-1:0] ms;
  assign ms = map_sel_ff[IW-1:0];
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr)
      `CCD_OFF_CTRL: rd_mux = ctrl_ff;
      `CCD_OFF_LEAF: rd_mux = leaf_ff;
      `CCD_OFF_RBX_LO: rd_mux = rbx_ff[31:0];
      `CCD_OFF_RBX_HI: rd_mux = rbx_ff[63:32];
      `CCD_OFF_RCX_LO: rd_mux = rcx_ff[31:0];
      `CCD_OFF_RCX_HI: rd_mux = rcx_ff[63:32];
      `CCD_OFF_DS_BASE: rd_mux = ds_base_ff;
      `CCD_OFF_DS_LIMIT: rd_mux = ds_limit_ff;
      `CCD_OFF_STATUS: rd_mux = {24'h0, status_ff};
      `CCD_OFF_RAX_LO: rd_mux = rax_ff[31:0];
      `CCD_OFF_RAX_HI: rd_mux = rax_ff[63:32];
      `CCD_OFF_FADDR_LO: rd_mux = faddr_ff[31:0];
      `CCD_OFF_FADDR_HI: rd_mux = faddr_ff[63:32];
      `CCD_OFF_MAP_SEL: rd_mux = {24'h0, map_sel_ff};
      `CCD_OFF_MAP_ATTR: rd_mux = {25'h0, map_type_ff[ms], 2'h0, map_busy_ff[ms],
                                   map_valid_ff[ms]};
      `CCD_OFF_MAP_OWNER: rd_mux = 32'(map_owner_ff[ms]);
      `CCD_OFF_CNT_LO: rd_mux = cnt_ff[ms][31:0];
      `CCD_OFF_CNT_HI: rd_mux = cnt_ff[ms][63:32];
      `CCD_OFF_FLAGS: rd_mux = flags_ff;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Address is taken and answered on the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CCD_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= addr_known(s_axi_araddr) ? `CCD_RESP_OKAY : `CCD_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_underflow;
    state_ff == ccd_pkg::ST_DECR && cnt_now == 64'h0;
  endsequence
  sequence s_restore;
    state_ff == ccd_pkg::ST_FIX ##1 state_ff == ccd_pkg::ST_DONE;
  endsequence
  a_underflow_restore: assert property (s_underflow |=> s_restore)
    else $error("underflow did not restore and finish");
  a_underflow_value: assert property (s_underflow |-> ##2 cnt_ff[par_idx_ff] == 64'h0)
    else $error("counter changed across underflow");
  a_success_clear: assert property (state_ff == ccd_pkg::ST_DECR && cnt_now != 64'h0 |=>
      !flags_ff[`CCD_FL_ZF] && rax_ff == `CCD_RAX_OK)
    else $error("success did not clear ZF and RAX");
  a_conflict_code: assert property (state_ff == ccd_pkg::ST_CHECK && !tgt_out && !sec_out &&
      map_busy_ff[tgt_idx] && leaf_ff == `CCD_LEAF_DEC && !lim_bad && !canon_bad &&
      ctrl_ff[`CCD_CTRL_CPL_HI:`CCD_CTRL_CPL_LO] == `CCD_CPL_KERNEL &&
      !ctrl_ff[`CCD_CTRL_XLAT_FAULT] && rbx_ff[`CCD_PAGE_SHIFT-1:0] == '0 |=>
      rax_ff == `CCD_ERR_CONFLICT && flags_ff[`CCD_FL_ZF] && state_ff == ccd_pkg::ST_DONE)
    else $error("conflict not reported");
  a_align_gp: assert property (state_ff == ccd_pkg::ST_CHECK && leaf_ff == `CCD_LEAF_DEC &&
      rbx_ff[`CCD_PAGE_SHIFT-1:0] != '0 |=> status_ff[`CCD_ST_GP])
    else $error("misaligned page operand not faulted");
  a_priv_gp: assert property (state_ff == ccd_pkg::ST_CHECK &&
      ctrl_ff[`CCD_CTRL_CPL_HI:`CCD_CTRL_CPL_LO] != `CCD_CPL_KERNEL |=>
      status_ff[`CCD_ST_GP] && state_ff == ccd_pkg::ST_IDLE)
    else $error("non-kernel caller not refused");
  a_fault_keeps: assert property (state_ff == ccd_pkg::ST_CHECK ##1
      (status_ff[`CCD_ST_GP] || status_ff[`CCD_ST_PF]) |->
      $stable(rax_ff) && $stable(flags_ff))
    else $error("fault changed RAX or flags");
  a_done_clears: assert property (state_ff == ccd_pkg::ST_DONE |=>
      flags_ff[`CCD_FL_CF] == 1'b0 && flags_ff[`CCD_FL_PF] == 1'b0 &&
      flags_ff[`CCD_FL_AF] == 1'b0 && flags_ff[`CCD_FL_OF] == 1'b0 &&
      flags_ff[`CCD_FL_SF] == 1'b0 && status_ff[`CCD_ST_DONE])
    else $error("arithmetic flags not cleared at completion");
  a_parent_gp: assert property (state_ff == ccd_pkg::ST_DECR |-> $past(parent_pa) ==
      $past(lin_rcx))
    else $error("decrement with mismatched parent");
  a_leaf_bound: assert property (go_pulse |-> ##[1:5] state_ff == ccd_pkg::ST_IDLE)
    else $error("leaf did not finish in five cycles");
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the child count decrement block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int fail_count = 0, n_checks = 0, cyc = 0;
  // Free-running 200 MHz clock
  always #2.5 aclk = ~aclk;
  ccd_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rready <= 1'b0;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // Start a leaf, poll until idle, then judge STATUS
  task go(input logic [31:0] rbx, input logic [31:0] ctl, input logic [31:0] st);
    wr(8'h08, rbx);
    wr(8'h00, ctl);
    do rd(8'h20, v); while (v[0] !== 1'b0);
    chk(v, st);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Page 1 regular owned by page 0, page 0 a control structure with count 1
  task t_success;
    wr(8'h04, 32'h0); wr(8'h34, 32'h1); wr(8'h38, 32'h21); wr(8'h3c, 32'h0);
    wr(8'h34, 32'h0); wr(8'h38, 32'h01); wr(8'h40, 32'h1);
    wr(8'h10, 32'h8000_0000); wr(8'h48, 32'h897);
    go(32'h8000_1000, 32'h9, 32'h02);
    rdchk(8'h24, 32'h0);
    rdchk(8'h48, 32'h002);
    rdchk(8'h40, 32'h0);
  endtask
  // Busy target reports conflict code in RAX and zero flag
  task t_conflict;
    wr(8'h34, 32'h1); wr(8'h38, 32'h23); wr(8'h40, 32'h5);
    go(32'h8000_1000, 32'h9, 32'h02);
    rdchk(8'h24, 32'h7);
    rdchk(8'h48, 32'h042);
    wr(8'h38, 32'h21);
  endtask
  // Counter at zero: restored, error code, zero flag
  task t_underflow;
    wr(8'h34, 32'h0); wr(8'h48, 32'h897);
    go(32'h8000_1000, 32'h9, 32'h02);
    rdchk(8'h24, 32'h8);
    rdchk(8'h48, 32'h042);
    rdchk(8'h40, 32'h0);
    rdchk(8'h44, 32'h0);
  endtask
  // Faults leave RAX and flags as they were
  task t_faults;
    go(32'h8000_1008, 32'h9, 32'h06);
    go(32'h8000_1000, 32'hf, 32'h06);
    go(32'h9000_0000, 32'h9, 32'h1a);
    rdchk(8'h2c, 32'h9000_0000);
    rdchk(8'h24, 32'h8);
    rdchk(8'h48, 32'h042);
    rd(8'h4c, v);
    chk({30'h0, rresp}, 32'h2);
  endtask
  // Canonical and segment checks, injected fault, bad second operand, map and parent faults
  task t_more;
    wr(8'h0c, 32'h0001_0000);
    go(32'h8000_1000, 32'h9, 32'h06);
    wr(8'h0c, 32'h0); wr(8'h1c, 32'h8000_0fff);
    go(32'h8000_1000, 32'h1, 32'h06);
    wr(8'h1c, 32'hffff_ffff);
    go(32'h8000_1000, 32'h11, 32'h06);
    go(32'h8000_1000, 32'h49, 32'h0a);
    wr(8'h10, 32'h7000_0000);
    go(32'h8000_1000, 32'h9, 32'h1a);
    rdchk(8'h2c, 32'h7000_0000);
    wr(8'h10, 32'h8000_0000); wr(8'h34, 32'h1); wr(8'h38, 32'h20);
    go(32'h8000_1000, 32'h9, 32'h1a);
    wr(8'h38, 32'h31);
    go(32'h8000_1000, 32'h9, 32'h1a);
    wr(8'h38, 32'h21); wr(8'h3c, 32'h2);
    go(32'h8000_1000, 32'h9, 32'h06);
    wr(8'h34, 32'h0); wr(8'h40, 32'h2);
    go(32'h8000_0000, 32'h1, 32'h02);
    rdchk(8'h40, 32'h1);
    rdchk(8'h24, 32'h0);
    wr(8'h4c, 32'h0);
    chk({30'h0, bresp}, 32'h2);
  endtask
  // Closing report
  task give_verdict;
    $display("checks=%0d fails=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_success; t_conflict; t_underflow; t_faults; t_more;
    give_verdict;
  end
endmodule
`default_nettype wire
